// ===== hw/ude_buf2.sv
// two-entry valid/ready buffer for dma words
`timescale 1ns/1ns
module ude_buf2 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // flush on dma stop
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire ude_pkg::ude_word_t in_word_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output ude_pkg::ude_word_t out_word_o
);
  ude_pkg::ude_word_t mem_q [2];
  logic [1:0] cnt_q;
  logic rd_q, wr_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_word_o = mem_q[rd_q];
  // pointer and count update
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (flush_i) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
    end
  end
  // storage, no reset needed for data
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wr_q] <= in_word_i;
  end
endmodule // ude_buf2

// ===== hw/ude_pkg.sv
// package for the interrupt enable and dma setup register block
// ==========================================================
// Function
// - bits 23..10 enable endpoints 14..1
// - bit 9 control in, bit 8 control out
// - bit 6 enables short packet interrupt
// - bit 5 enables pseudo frame interrupt
// - bit 4 frame start, bit 3 transfer end
// - bits 2,1,0 suspend, resume, bus reset
// - bus reset clears only dma run bit
// - dma setup command moves one word
// - bit 15 ends transfer at count zero
// - bit 14 ends on short out packet
// - bit 8 shows last access byte/word
// - bits 7..4 hold dma endpoint index
// - dma run one starts, zero terminates
// - dma run reads back present state
// - burst field selects 1/4/8/16 bytes
// - disabled events are never latched
// - bus reset keeps interrupt enables
// - re-enable reloads counter from count register
package ude_pkg;
  // command codes
  localparam logic [7:0] CMD_IEN_WR = 8'hc2;
  localparam logic [7:0] CMD_IEN_RD = 8'hc3;
  localparam logic [7:0] CMD_DMA_WR = 8'hf0;
  localparam logic [7:0] CMD_DMA_RD = 8'hf1;
  localparam logic [7:0] CMD_CNT_WR = 8'hf2;
  localparam logic [7:0] CMD_CNT_RD = 8'hf3;
  // reset values and write masks
  localparam logic [31:0] IEN_RESET = 32'h0000_0000;
  localparam logic [15:0] DMA_RESET = 16'h0000;
  localparam logic [31:0] IEN_WMASK = 32'h00ff_ff7f;
  localparam logic [15:0] DMA_WMASK = 16'hc0fb;
  // dma setup and interrupt enable field positions and event width
  localparam int DMA_CNTZ_BIT = 15;
  localparam int DMA_SHORT_BIT = 14;
  localparam int DMA_WORD_BIT = 8;
  localparam int DMA_EP_LO = 4;
  localparam int DMA_RUN_BIT = 3;
  localparam int IEN_EOT_BIT = 3;
  localparam int IEN_SP_BIT = 6;
  localparam int IEN_EV_W = 24;
  // burst codes and byte counts
  localparam logic [1:0] BURST_1 = 2'h0;
  localparam logic [1:0] BURST_4 = 2'h1;
  localparam logic [1:0] BURST_8 = 2'h2;
  localparam logic [1:0] BURST_16 = 2'h3;
  localparam logic [4:0] BYTES_1 = 5'h01;
  localparam logic [4:0] BYTES_4 = 5'h04;
  localparam logic [4:0] BYTES_8 = 5'h08;
  localparam logic [4:0] BYTES_16 = 5'h10;
  // bus phase carrier
  typedef struct packed {
    logic cmd;
    logic wr;
    logic [15:0] data;
  } ude_bus_t;
  // dma data word carrier
  typedef struct packed {
    logic [15:0] data;
    logic odd;
  } ude_word_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LO = 2'b01,
    PH_HI = 2'b10
  } ude_phase_t;
endpackage

// ===== hw/ude_top.sv
// interrupt enable and dma setup registers with dma word path
`timescale 1ns/1ns
module ude_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // processor bus phases, one per cycle when valid
  input wire logic bus_valid_i,
  input wire ude_pkg::ude_bus_t bus_i,
  output logic [15:0] bus_rdata_o,
  output logic bus_rvalid_o,
  // usb side events
  input wire logic usb_bus_reset_i,
  input wire logic [15:0] ep_event_i,
  input wire logic [7:0] bus_event_i,
  input wire logic short_out_pkt_i,
  // interrupt status latch controls
  input wire logic [ude_pkg::IEN_EV_W-1:0] status_clear_i,
  output logic [ude_pkg::IEN_EV_W-1:0] irq_status_o,
  output logic irq_o,
  // dma words from endpoint side
  input wire logic ep_valid_i,
  output logic ep_ready_o,
  input wire ude_pkg::ude_word_t ep_word_i,
  // dma words to external controller
  output logic dma_valid_o,
  input wire logic dma_ready_i,
  output logic [15:0] dma_data_o,
  // dma control outputs
  output logic dma_run_o,
  output logic [3:0] dma_endpoint_o,
  output logic [4:0] burst_bytes_o,
  output logic end_of_transfer_o
);
  localparam int IEN_EVW = ude_pkg::IEN_EV_W;
  // ==========================================================
  // command decode
  // ==========================================================
  ude_pkg::ude_phase_t phase_q, phase_d;
  logic [7:0] cmd_q;
  logic [15:0] lo_q;
  logic [31:0] ien_q;
  logic [15:0] dma_q;
  logic [15:0] cnt_reg_q, cnt_q;
  logic word_flag_q;
  ude_pkg::ude_word_t out_word;
  logic buf_valid;
  wire data_ph = bus_valid_i && !bus_i.cmd;
  wire cmd_ph = bus_valid_i && bus_i.cmd;
  wire is_ien = (cmd_q == ude_pkg::CMD_IEN_WR) || (cmd_q == ude_pkg::CMD_IEN_RD);
  wire ien_wr_lo = data_ph && phase_q == ude_pkg::PH_LO && cmd_q == ude_pkg::CMD_IEN_WR;
  wire ien_wr_hi = data_ph && phase_q == ude_pkg::PH_HI && cmd_q == ude_pkg::CMD_IEN_WR;
  wire dma_wr = data_ph && phase_q == ude_pkg::PH_LO && cmd_q == ude_pkg::CMD_DMA_WR;
  wire cnt_wr = data_ph && phase_q == ude_pkg::PH_LO && cmd_q == ude_pkg::CMD_CNT_WR;
  wire dma_run = dma_q[ude_pkg::DMA_RUN_BIT];
  wire run_wr = dma_wr && bus_i.data[ude_pkg::DMA_RUN_BIT];
  wire start = run_wr && !dma_run;
  // phase sequencing: ien takes two words, others one
  always_comb begin
    phase_d = phase_q;
    if (cmd_ph) begin
      phase_d = ude_pkg::PH_LO;
    end else if (data_ph) begin
      unique case (phase_q)
        ude_pkg::PH_IDLE: phase_d = ude_pkg::PH_IDLE;
        ude_pkg::PH_LO: phase_d = is_ien ? ude_pkg::PH_HI : ude_pkg::PH_IDLE;
        ude_pkg::PH_HI: phase_d = ude_pkg::PH_IDLE;
        default: phase_d = ude_pkg::PH_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= ude_pkg::PH_IDLE;
      cmd_q <= 8'h00;
      lo_q <= 16'h0000;
    end else begin
      phase_q <= phase_d;
      if (cmd_ph) cmd_q <= bus_i.data[7:0];
      if (ien_wr_lo) lo_q <= bus_i.data;
    end
  end
  // ==========================================================
  // registers
  // ==========================================================
  // enables stored as written, reserved masked
  // bus reset does not touch enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ien_q <= ude_pkg::IEN_RESET;
    else if (ien_wr_hi) ien_q <= {bus_i.data, lo_q} & ude_pkg::IEN_WMASK;
  end
  // bus reset clears only the run bit
  logic [15:0] dma_d;
  always_comb begin
    dma_d = dma_q;
    if (dma_wr) dma_d = bus_i.data & ude_pkg::DMA_WMASK;
    if (usb_bus_reset_i || end_of_transfer_o) dma_d[ude_pkg::DMA_RUN_BIT] = 1'b0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) dma_q <= ude_pkg::DMA_RESET;
    else dma_q <= dma_d;
  end
  wire drain = dma_valid_o && dma_ready_i;
  // bytes carried by the word leaving now
  wire [15:0] step = out_word.odd ? 16'h0001 : 16'h0002;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg_q <= 16'h0000;
      cnt_q <= 16'h0000;
    end else begin
      if (cnt_wr) cnt_reg_q <= bus_i.data;
      if (start) cnt_q <= cnt_wr ? bus_i.data : cnt_reg_q;
      // saturate so a word larger than the remainder cannot wrap the count
      else if (drain) cnt_q <= (cnt_q > step) ? cnt_q - step : 16'h0000;
    end
  end
  // ==========================================================
  // dma word path
  // ==========================================================
  wire flush = !dma_run;
  ude_buf2 u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .in_valid_i(ep_valid_i && dma_run),
    .in_ready_o(ep_ready_o),
    .in_word_i(ep_word_i),
    .out_valid_o(buf_valid),
    .out_ready_i(dma_ready_i && dma_run),
    .out_word_o(out_word)
  );
  assign dma_data_o = out_word.data;
  // held words must not leak out in the cycle before the flush lands
  assign dma_valid_o = buf_valid && dma_run;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) word_flag_q <= 1'b0;
    else if (drain) word_flag_q <= !out_word.odd;
  end
  // count zero end, short packet end
  wire cnt_last = drain && dma_q[ude_pkg::DMA_CNTZ_BIT] && cnt_q <= step && cnt_q != 16'h0000;
  wire short_end = dma_run && dma_q[ude_pkg::DMA_SHORT_BIT] && short_out_pkt_i;
  assign end_of_transfer_o = dma_run && (cnt_last || short_end);
  // ==========================================================
  // interrupt status latch
  // ==========================================================
  logic [IEN_EVW-1:0] stat_q;
  wire [IEN_EVW-1:0] raw_ev = {ep_event_i, bus_event_i | {1'b0, short_end, 2'b00,
                               end_of_transfer_o, 3'b000}};
  // only enabled events latch; set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) stat_q <= '0;
    else stat_q <= (stat_q & ~status_clear_i) | (raw_ev & ien_q[IEN_EVW-1:0]);
  end
  assign irq_status_o = stat_q;
  assign irq_o = |stat_q;
  // ==========================================================
  // read data and control outputs
  // ==========================================================
  // run bit reads back live state
  wire [15:0] dma_rd = {dma_q[15:9], word_flag_q, dma_q[7:0]};
  wire rd_ph = data_ph && phase_q != ude_pkg::PH_IDLE;
  wire [15:0] rd_sel = (cmd_q == ude_pkg::CMD_IEN_RD) ?
                       (phase_q == ude_pkg::PH_LO ? ien_q[15:0] : ien_q[31:16]) :
                       (cmd_q == ude_pkg::CMD_DMA_RD) ? dma_rd :
                       (cmd_q == ude_pkg::CMD_CNT_RD) ? cnt_q : 16'h0000;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= 16'h0000;
      bus_rvalid_o <= 1'b0;
    end else begin
      bus_rvalid_o <= rd_ph && !bus_i.wr;
      if (rd_ph && !bus_i.wr) bus_rdata_o <= rd_sel;
    end
  end
  assign dma_run_o = dma_run;
  assign dma_endpoint_o = dma_q[ude_pkg::DMA_EP_LO +: 4];
  assign burst_bytes_o = (dma_q[1:0] == ude_pkg::BURST_1) ? ude_pkg::BYTES_1 :
                         (dma_q[1:0] == ude_pkg::BURST_4) ? ude_pkg::BYTES_4 :
                         (dma_q[1:0] == ude_pkg::BURST_8) ? ude_pkg::BYTES_8 :
                         ude_pkg::BYTES_16;
  // ==========================================================
  // assertions
  // ==========================================================
  a_reset_run_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    usb_bus_reset_i && !dma_wr |=> !dma_run_o && $stable(dma_q[15:4]))
    else $error("bus reset did not clear only run bit");
  a_reset_keeps_ien: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    usb_bus_reset_i && !ien_wr_hi |=> $stable(ien_q))
    else $error("bus reset changed enables");
  a_disabled_no_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ien_q[0] && !stat_q[0] |=> !stat_q[0])
    else $error("disabled event latched");
  a_enabled_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ep_event_i[2] && ien_q[10] |=> stat_q[10])
    else $error("enabled endpoint event lost");
  a_reload_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && !cnt_wr |=> cnt_q == $past(cnt_reg_q))
    else $error("counter not reloaded");
  a_stop_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dma_wr && !bus_i.data[ude_pkg::DMA_RUN_BIT] |=> !dma_run_o ##1 !dma_valid_o)
    else $error("dma not terminated");
  a_short_eot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dma_run && dma_q[ude_pkg::DMA_SHORT_BIT] && short_out_pkt_i |-> end_of_transfer_o)
    else $error("short packet end missing");
  a_word_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    drain |=> word_flag_q == !$past(out_word.odd))
    else $error("last access flag wrong");
  a_ien_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ien_wr_hi |=> ien_q[31:24] == 8'h00 && ien_q[7] == 1'b0)
    else $error("reserved enable bits set");
  a_burst_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dma_q[1:0] == ude_pkg::BURST_8 |-> burst_bytes_o == ude_pkg::BYTES_8)
    else $error("burst decode wrong");
  a_eot_at_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_last |=> cnt_q == 16'h0000 && !dma_run_o)
    else $error("count end left dma running");
  c_dma_start: cover property (@(posedge clk_i) disable iff (!rst_n_i) start ##[1:20] drain);
  c_eot: cover property (@(posedge clk_i) disable iff (!rst_n_i) end_of_transfer_o);
  c_buf_full: cover property (@(posedge clk_i) disable iff (!rst_n_i) !ep_ready_o && dma_run);
  c_ien_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) ien_wr_hi);
endmodule // ude_top

// ===== tb/ude_dma_sink.sv
// model of the external dma controller draining words
`timescale 1ns/1ns
module ude_dma_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // word stream from the block
  input wire logic dma_valid_i,
  input wire logic [15:0] dma_data_i,
  output logic dma_ready_o,
  // bench control and observation
  input wire logic stall_i,
  output logic [15:0] last_o,
  output int count_o
);
  // ==========================================================
  // one word per transfer
  // ready drops while stalled so the buffer must hold the words
  assign dma_ready_o = !stall_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_o <= 16'h0000;
      count_o <= 0;
    end else if (dma_valid_i && dma_ready_o) begin
      last_o <= dma_data_i;
      count_o <= count_o + 1;
    end
  end
endmodule // ude_dma_sink

// ===== tb/ude_top_bench.sv
// self-checking bench for the enable and dma setup registers
`timescale 1ns/1ns
module ude_top_bench;
  logic clk_i, rst_n_i, bus_valid_i, bus_rvalid_o, usb_bus_reset_i, short_out_pkt_i;
  logic irq_o, ep_valid_i, ep_ready_o, dma_valid_o, dma_ready_i, dma_run_o, end_of_transfer, stall;
  ude_pkg::ude_bus_t bus_i;
  ude_pkg::ude_word_t ep_word_i;
  logic [15:0] bus_rdata_o, ep_event_i, dma_data_o, last;
  logic [7:0] bus_event_i;
  logic [23:0] status_clear_i, irq_status_o;
  logic [3:0] dma_endpoint_o;
  logic [4:0] burst_bytes_o;
  logic [31:0] v;
  int miscompares = 0, n_checks = 0, cnt;
  ude_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_valid_i(bus_valid_i), .bus_i(bus_i),
    .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o), .usb_bus_reset_i(usb_bus_reset_i),
    .ep_event_i(ep_event_i), .bus_event_i(bus_event_i), .short_out_pkt_i(short_out_pkt_i),
    .status_clear_i(status_clear_i), .irq_status_o(irq_status_o), .irq_o(irq_o),
    .ep_valid_i(ep_valid_i), .ep_ready_o(ep_ready_o), .ep_word_i(ep_word_i),
    .dma_valid_o(dma_valid_o), .dma_ready_i(dma_ready_i), .dma_data_o(dma_data_o),
    .dma_run_o(dma_run_o), .dma_endpoint_o(dma_endpoint_o), .burst_bytes_o(burst_bytes_o),
    .end_of_transfer_o(end_of_transfer));
  ude_dma_sink sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .dma_valid_i(dma_valid_o),
    .dma_data_i(dma_data_o), .dma_ready_o(dma_ready_i), .stall_i(stall), .last_o(last),
    .count_o(cnt));
  // ==========================================================
  // clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ==========================================================
  // shared helpers
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  // one bus phase per falling edge
  task automatic ph(logic c, logic w, logic [15:0] d);
    @(negedge clk_i);
    bus_valid_i = 1'b1;
    bus_i = {c, w, d};
  endtask
  task automatic wr(logic [7:0] code, logic [31:0] d, int n);
    ph(1'b1, 1'b0, {8'h00, code});
    ph(1'b0, 1'b1, d[15:0]);
    if (n == 2) ph(1'b0, 1'b1, d[31:16]);
    @(negedge clk_i);
    bus_valid_i = 1'b0;
  endtask
  // answer may trail the data phase, so wait a bounded few cycles
  task automatic rd(logic [7:0] code, int n, output logic [31:0] d);
    int k;
    d = 32'h0000_0000;
    ph(1'b1, 1'b0, {8'h00, code});
    for (int i = 0; i < n; i++) begin
      ph(1'b0, 1'b0, 16'h0000);
      @(negedge clk_i);
      bus_valid_i = 1'b0;
      for (k = 0; k < 4 && bus_rvalid_o !== 1'b1; k++) @(negedge clk_i);
      if (k == 4) begin
        chk("rvalid", 1, 0);
        results();
      end
      d[16*i+:16] = bus_rdata_o;
    end
  endtask
  task automatic pulse_rst;
    @(negedge clk_i);
    usb_bus_reset_i = 1'b1;
    @(negedge clk_i);
    usb_bus_reset_i = 1'b0;
  endtask
  task automatic wait_eot;
    int k;
    for (k = 0; k < 20 && end_of_transfer !== 1'b1; k++) @(negedge clk_i);
    chk("eot_seen", 1, k < 20);
    @(negedge clk_i);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_ien;
    rd(ude_pkg::CMD_IEN_RD, 2, v);
    chk("ien_reset", ude_pkg::IEN_RESET, v);
    wr(ude_pkg::CMD_IEN_WR, 32'hffff_ffff, 2);
    rd(ude_pkg::CMD_IEN_RD, 2, v);
    chk("ien_bits", 32'h00ff_ff7f, v);
    pulse_rst();
    rd(ude_pkg::CMD_IEN_RD, 2, v);
    chk("ien_busrst", 32'h00ff_ff7f, v);
  endtask
  task automatic t_burst;
    logic [4:0] tbl [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    chk("burst_reset", 5'h01, burst_bytes_o);
    for (int i = 0; i < 4; i++) begin
      wr(ude_pkg::CMD_DMA_WR, i, 1);
      chk("burst_bytes", tbl[i], burst_bytes_o);
    end
  endtask
  task automatic t_cfg;
    wr(ude_pkg::CMD_DMA_WR, 32'h0000_ffff, 1);
    chk("run_on", 1, dma_run_o);
    chk("endpoint", 4'hf, dma_endpoint_o);
    rd(ude_pkg::CMD_DMA_RD, 1, v);
    chk("cfg_read", 32'h0000_c0fb, v);
    pulse_rst();
    rd(ude_pkg::CMD_DMA_RD, 1, v);
    chk("cfg_busrst", 32'h0000_c0f3, v);
    chk("run_off", 0, dma_run_o);
  endtask
  task automatic t_irq;
    wr(ude_pkg::CMD_IEN_WR, 32'h0, 2);
    @(negedge clk_i) bus_event_i = 8'h11;
    @(negedge clk_i) bus_event_i = 8'h00;
    wr(ude_pkg::CMD_IEN_WR, 32'h10, 2);
    chk("no_latch", 0, {irq_o, irq_status_o});
    @(negedge clk_i) bus_event_i = 8'h10;
    @(negedge clk_i) bus_event_i = 8'h00;
    @(negedge clk_i);
    chk("sof_latch", 25'h100_0010, {irq_o, irq_status_o});
    status_clear_i = 24'h00_0010;
    @(negedge clk_i) status_clear_i = 24'h0;
    @(negedge clk_i);
    chk("cleared", 0, {irq_o, irq_status_o});
    wr(ude_pkg::CMD_IEN_WR, 32'h400, 2);
    @(negedge clk_i) ep_event_i = 16'h0004;
    @(negedge clk_i) ep_event_i = 16'h0000;
    @(negedge clk_i);
    chk("ep_latch", 25'h100_0400, {irq_o, irq_status_o});
  endtask
  // words pile up in the buffer while the sink stalls
  task automatic push(logic [15:0] d, logic exp_ok);
    @(negedge clk_i);
    ep_valid_i = 1'b1;
    ep_word_i = {d, 1'b0};
    #1 chk("ep_ready", exp_ok, ep_ready_o);
    @(negedge clk_i) ep_valid_i = 1'b0;
  endtask
  task automatic t_path;
    stall = 1'b1;
    wr(ude_pkg::CMD_CNT_WR, 32'h4, 1);
    // short mode left clear on this transfer
    wr(ude_pkg::CMD_DMA_WR, 32'h8008, 1);
    push(16'h1111, 1'b1);
    push(16'h2222, 1'b1);
    push(16'h3333, 1'b0);
    @(negedge clk_i) stall = 1'b0;
    wait_eot();
    chk("words", 2, cnt);
    chk("last", 16'h2222, last);
    chk("run_end", 0, dma_run_o);
    rd(ude_pkg::CMD_DMA_RD, 1, v);
    chk("word_flag", 32'h8100, v);
    wr(ude_pkg::CMD_DMA_WR, 32'h4008, 1);
    @(negedge clk_i) short_out_pkt_i = 1'b1;
    #1 chk("short_eot", 1, end_of_transfer);
    @(negedge clk_i) short_out_pkt_i = 1'b0;
    @(negedge clk_i);
    chk("short_run", 0, dma_run_o);
    rd(ude_pkg::CMD_CNT_RD, 1, v);
    chk("cnt_reload", 32'h0000_0004, v);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    {bus_valid_i, usb_bus_reset_i, short_out_pkt_i, ep_valid_i, stall} = '0;
    bus_i = '0;
    ep_word_i = '0;
    ep_event_i = 16'h0000;
    bus_event_i = 8'h00;
    status_clear_i = 24'h0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_ien();
    t_burst();
    t_cfg();
    t_irq();
    t_path();
    results();
  end
endmodule // ude_top_bench
